// ===== src/pga_pkg.sv
// shared constants for the automatic acknowledge responder
`default_nettype none
package pga_pkg;
  // register index and bus byte address (index times four)
  localparam logic [7:0] REG_ACK_HDR_IDX  = 8'h03;
  localparam logic [7:0] REG_ACK_STAT_IDX = 8'h04;
  localparam logic [7:0] REG_ACK_HDR_ADDR = 8'h0C;
  localparam logic [7:0] REG_ACK_STAT_ADDR = 8'h10;
  localparam logic [7:0] ACK_HDR_RESET    = 8'h20;
  // field positions in ack_header_config
  localparam int BIT_POWER_ROLE = 7;
  localparam int BIT_SPEC_HI    = 6;
  localparam int BIT_SPEC_LO    = 5;
  localparam int BIT_DATA_ROLE  = 4;
  localparam int BIT_RESERVED   = 3;
  localparam int BIT_AUTO_ACK   = 2;
  // writable mask: reserved bit stays zero
  localparam logic [7:0] ACK_HDR_WMASK = 8'hF7;
  // packet type codes on the link side
  localparam logic [2:0] SOP_PLAIN = 3'h0;
  // message type code of a GoodCRC control message
  localparam logic [4:0] MSG_GOODCRC = 5'h01;
  // answer for an unmapped read
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage
`default_nettype wire

// ===== src/pga_hdr_build.sv
// builds the 16-bit GoodCRC message header
`timescale 1ns/1ns
`default_nettype none
module pga_hdr_build (
  input  wire logic [7:0]  cfg,
  input  wire logic [2:0]  sop_type,
  input  wire logic [2:0]  msg_id,
  output logic      [15:0] header
);
  logic is_sop;
  // role bits only carry meaning for plain SOP; cable ends see zero
  always_comb
  begin
    is_sop = (sop_type == pga_pkg::SOP_PLAIN);
    header = 16'h0000;
    header[4:0] = pga_pkg::MSG_GOODCRC;
    // [RL3] data role bit
    header[5] = is_sop & cfg[pga_pkg::BIT_DATA_ROLE];
    // [RL2] copy spec revision
    header[7] = cfg[pga_pkg::BIT_SPEC_HI];
    header[6] = cfg[pga_pkg::BIT_SPEC_LO];
    // [RL1] power role bit
    header[8] = is_sop & cfg[pga_pkg::BIT_POWER_ROLE];
    header[11:9] = msg_id; // echo id of the acknowledged message
  end
endmodule
`default_nettype wire

// ===== src/pga_auto_ack.sv
// automatic GoodCRC responder with Avalon-MM register slave
// Notes on behaviour
// [RL1] For SOP, the header's port power role bit follows the power role bit.
// [RL2] The two spec revision bits are copied into the header revision field.
// [RL3] For SOP, the header's port data role bit follows the data role bit.
// [RL4] With auto ack on, a good-CRC message starts the transmitter at once; here tx_start comes a cycle later, and not at all while ack_busy is high.
// [RL5] The GoodCRC goes out on the same SOP* type the message came on.
// [RL6] Software never writes the reserved bit between data role and enable.
// [RL7] With auto ack off, no transmit is started and no GoodCRC is sent.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module pga_auto_ack (
  input  wire logic        mclk,
  input  wire logic        resetn,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // receiver side
  input  wire logic        rx_msg_done,
  input  wire logic        rx_crc_ok,
  input  wire logic [2:0]  rx_sop_type,
  input  wire logic [2:0]  rx_msg_id,
  // transmitter side
  input  wire logic        tx_done,
  output logic             tx_start,
  output logic      [2:0]  tx_sop_type,
  output logic      [15:0] tx_header,
  output logic             ack_busy
);
  typedef enum logic [1:0] {PGA_IDLE, PGA_START, PGA_WAIT} pga_state_e;

  // bus handshake state
  logic [31:0] rdata_r, rdata_nxt;
  logic        wait_r, wait_nxt;
  // configuration state
  logic [7:0]  cfg_r, cfg_nxt;
  // responder state
  pga_state_e  st_r, st_nxt;
  logic        start_r, start_nxt;
  logic [2:0]  sop_r, sop_nxt;
  logic [15:0] hdr_r, hdr_nxt;
  logic        busy_r, busy_nxt;
  // activity state
  logic [7:0]  sent_r, sent_nxt;
  // decoded strobes
  logic [15:0] hdr_built;
  logic        bus_req;
  logic        bus_go;
  logic        cfg_wr;
  logic        trigger;
  logic        ack_end;

  pga_hdr_build u_hdr (
    .cfg      (cfg_r),
    .sop_type (rx_sop_type),
    .msg_id   (rx_msg_id),
    .header   (hdr_built)
  );

  // address decode, shared by the write path and the read mux
  function automatic logic is_cfg_addr(input logic [7:0] a);
    return (a == pga_pkg::REG_ACK_HDR_ADDR);
  endfunction

  function automatic logic is_stat_addr(input logic [7:0] a);
    return (a == pga_pkg::REG_ACK_STAT_ADDR);
  endfunction

  // read mux; status is read-only and unmapped space reads zero
  function automatic logic [31:0] read_mux(input logic [7:0] a,
                                           input logic [7:0] c,
                                           input logic       busy,
                                           input logic [7:0] cnt);
    logic [31:0] d;
    d = pga_pkg::UNMAPPED_DATA;
    if (is_cfg_addr(a))
      d = {24'h000000, c};
    else if (is_stat_addr(a))
      d = {16'h0000, cnt, 7'h00, busy};
    return d;
  endfunction

  // strobes; bus_go marks the edge at which the master sees waitrequest
  // low; a write held past that edge lands again every second cycle
  always_comb
  begin
    bus_req = avs_read | avs_write;
    bus_go  = bus_req & ~wait_r;
    cfg_wr  = bus_go & avs_write & is_cfg_addr(avs_address);
    // [RL4] good CRC with enable set
    // [RL7] enable clear blocks it
    trigger = rx_msg_done & rx_crc_ok & cfg_r[pga_pkg::BIT_AUTO_ACK];
    ack_end = (st_r == PGA_WAIT) & tx_done;
  end

  // handshake: every access answers on the second cycle
  always_comb
  begin
    wait_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    if (bus_req & wait_r)
    begin
      wait_nxt  = 1'b0;
      rdata_nxt = read_mux(avs_address, cfg_r, busy_r, sent_r);
    end
  end

  // handshake registers; read data holds until the next access
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_r <= 32'h00000000;
      wait_r  <= 1'b1;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      wait_r  <= wait_nxt;
    end
  end

  // configuration: writes land at the edge that ends the wait
  always_comb
  begin
    cfg_nxt = cfg_r;
    // [RL6] reserved bit masked
    if (cfg_wr)
      cfg_nxt = avs_writedata[7:0] & pga_pkg::ACK_HDR_WMASK;
  end

  // configuration register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cfg_r <= pga_pkg::ACK_HDR_RESET;
    else
      cfg_r <= cfg_nxt;
  end

  // responder: a message arriving while busy is not acknowledged, since
  // the header register must hold until the transmitter reports done
  always_comb
  begin
    st_nxt    = st_r;
    start_nxt = 1'b0;
    sop_nxt   = sop_r;
    hdr_nxt   = hdr_r;
    case (st_r)
      PGA_IDLE:
        if (trigger)
        begin
          st_nxt    = PGA_START;
          start_nxt = 1'b1;
          // [RL5] echo packet type
          sop_nxt   = rx_sop_type;
          hdr_nxt   = hdr_built;
        end
      PGA_START:
        st_nxt = PGA_WAIT; // tx_done is not looked at in the start cycle
      PGA_WAIT:
        if (ack_end)
          st_nxt = PGA_IDLE;
      default:
        st_nxt = PGA_IDLE;
    endcase
    // busy follows the next state so the output comes from a flop
    busy_nxt = (st_nxt != PGA_IDLE);
  end

  // responder registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r    <= PGA_IDLE;
      start_r <= 1'b0;
      sop_r   <= 3'h0;
      hdr_r   <= 16'h0000;
      busy_r  <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      start_r <= start_nxt;
      sop_r   <= sop_nxt;
      hdr_r   <= hdr_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // activity gauge: counts finished acks and wraps, only a rough measure
  always_comb
  begin
    sent_nxt = sent_r;
    if (ack_end)
      sent_nxt = sent_r + 8'h01;
  end

  // activity register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      sent_r <= 8'h00;
    else
      sent_r <= sent_nxt;
  end

  // outputs straight from flops
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign tx_start        = start_r;
  assign tx_sop_type     = sop_r;
  assign tx_header       = hdr_r;
  assign ack_busy        = busy_r;
endmodule
`default_nettype wire

// ===== bench/pga_auto_ack_properties.sv
// concurrent checks on the responder ports
`timescale 1ns/1ns
`default_nettype none
module pga_auto_ack_properties (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        rx_msg_done,
  input wire logic        rx_crc_ok,
  input wire logic [2:0]  rx_sop_type,
  input wire logic [2:0]  rx_msg_id,
  input wire logic        tx_start,
  input wire logic [2:0]  tx_sop_type,
  input wire logic [15:0] tx_header,
  input wire logic        ack_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // a received message that passed its CRC check
  sequence s_good_msg;
    rx_msg_done && rx_crc_ok;
  endsequence
  // busy rises with the start pulse and outlasts it
  sequence s_start_pulse;
    ack_busy ##1 !tx_start && ack_busy;
  endsequence
  // start only follows a good message one cycle before
  property p_src; tx_start |-> $past(rx_msg_done && rx_crc_ok); endproperty
  a_src: assert property (p_src) else $error("start without good message");
  property p_pulse; tx_start |-> s_start_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("start not a busy pulse");
  property p_type; tx_start |-> tx_sop_type == $past(rx_sop_type); endproperty
  a_type: assert property (p_type) else $error("reply on wrong packet type");
  property p_id;
    s_good_msg ##1 tx_start |-> tx_header[4:0] == pga_pkg::MSG_GOODCRC &&
      tx_header[11:9] == $past(rx_msg_id) && tx_header[15:12] == 4'h0;
  endproperty
  a_id: assert property (p_id) else $error("bad reply header");
  // role bits only carried for plain packets
  property p_pr;
    tx_start && tx_sop_type != pga_pkg::SOP_PLAIN |-> !tx_header[8];
  endproperty
  a_pr: assert property (p_pr) else $error("power role on non plain");
  property p_dr;
    tx_start && tx_sop_type != pga_pkg::SOP_PLAIN |-> !tx_header[5];
  endproperty
  a_dr: assert property (p_dr) else $error("data role on non plain");
  property p_hold;
    ack_busy && !tx_start |-> $stable(tx_header) && $stable(tx_sop_type);
  endproperty
  a_hold: assert property (p_hold) else $error("reply moved while busy");
  // a new start only from idle
  property p_idle; tx_start |-> !$past(ack_busy); endproperty
  a_idle: assert property (p_idle) else $error("start while still busy");
endmodule
bind pga_auto_ack pga_auto_ack_properties u_prop (
  .mclk        (mclk),
  .resetn      (resetn),
  .rx_msg_done (rx_msg_done),
  .rx_crc_ok   (rx_crc_ok),
  .rx_sop_type (rx_sop_type),
  .rx_msg_id   (rx_msg_id),
  .tx_start    (tx_start),
  .tx_sop_type (tx_sop_type),
  .tx_header   (tx_header),
  .ack_busy    (ack_busy)
);
`default_nettype wire

// ===== bench/pga_tx_model.sv
// transmitter stand-in: answers each start with a done pulse
`timescale 1ns/1ns
`default_nettype none
module pga_tx_model (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       tx_start,
  input  wire logic [3:0] dly,
  output logic            tx_done
);
  logic [3:0] cnt_r;
  // count down from start; dly sets prompt or slow reply
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= 4'h0;
      tx_done <= 1'b0;
    end
    else
    begin
      tx_done <= (cnt_r == 4'h1);
      cnt_r <= tx_start ? dly : ((cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0);
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_pga_auto_ack.sv
// self-checking bench for the auto ack responder
`timescale 1ns/1ns
`default_nettype none
module tb_pga_auto_ack;
  logic        mclk, resetn, avs_read, avs_write, avs_waitrequest, tx_done;
  logic        rx_msg_done, rx_crc_ok, tx_start, ack_busy;
  logic [7:0]  avs_address, c;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0]  rx_sop_type, rx_msg_id, tx_sop_type, s;
  logic [15:0] tx_header;
  logic [3:0]  dly;
  int          bad_count = 0;
  int          n_tests = 0;
  pga_auto_ack uut (
    .mclk            (mclk),
    .resetn          (resetn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .rx_msg_done     (rx_msg_done),
    .rx_crc_ok       (rx_crc_ok),
    .rx_sop_type     (rx_sop_type),
    .rx_msg_id       (rx_msg_id),
    .tx_done         (tx_done),
    .tx_start        (tx_start),
    .tx_sop_type     (tx_sop_type),
    .tx_header       (tx_header),
    .ack_busy        (ack_busy)
  );
  pga_tx_model u_tx (
    .mclk     (mclk),
    .resetn   (resetn),
    .tx_start (tx_start),
    .dly      (dly),
    .tx_done  (tx_done)
  );
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, !w};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
  endtask
  // one received message; r packs busy, start, type and header
  task automatic msg(input logic [2:0] t, input logic [2:0] id,
                     input logic ok, output logic [31:0] r);
    @(posedge mclk);
    {rx_msg_done, rx_crc_ok, rx_sop_type, rx_msg_id} <= {1'b1, ok, t, id};
    @(posedge mclk);
    rx_msg_done <= 1'b0;
    @(negedge mclk);
    r = {11'h000, ack_busy, tx_start, tx_sop_type, tx_header};
    repeat (10) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // roles, revisions and packet types, then refusals and status
  initial
  begin
    {resetn, avs_read, avs_write, rx_msg_done, rx_crc_ok} = 5'h00;
    {avs_address, avs_writedata, rx_sop_type, rx_msg_id, dly} = 50'h0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    bus(1'b0, pga_pkg::REG_ACK_HDR_ADDR, 32'h0, q);
    chk(q, {24'h0, pga_pkg::ACK_HDR_RESET});
    for (int i = 0; i < 8; i++)
    begin
      c = {i[2], 1'b0, i[0], i[1], 4'h4};
      s = i[0] ? 3'(i) : 3'h0;
      dly <= {2'b00, i[0], 1'b1};
      bus(1'b1, pga_pkg::REG_ACK_HDR_ADDR, {24'h0, c}, q);
      bus(1'b0, pga_pkg::REG_ACK_HDR_ADDR, 32'h0, q);
      chk(q, {24'h0, c});
      msg(s, 3'(i), 1'b1, q);
      chk(q, {11'h000, 2'b11, s, 4'h0, 3'(i), c[7] & (s == 3'h0), c[6:5],
              c[4] & (s == 3'h0), pga_pkg::MSG_GOODCRC});
    end
    bus(1'b1, pga_pkg::REG_ACK_HDR_ADDR, 32'h30, q);
    msg(3'h0, 3'h1, 1'b1, q);
    chk({30'h0, q[20:19]}, 32'h0);
    bus(1'b1, pga_pkg::REG_ACK_HDR_ADDR, 32'h34, q);
    msg(3'h0, 3'h1, 1'b0, q);
    chk({30'h0, q[20:19]}, 32'h0);
    // status is read-only and unmapped writes go nowhere
    bus(1'b1, pga_pkg::REG_ACK_STAT_ADDR, 32'h0000FFFF, q);
    bus(1'b1, 8'h40, 32'h000000FF, q);
    bus(1'b0, pga_pkg::REG_ACK_HDR_ADDR, 32'h0, q);
    chk(q, 32'h00000034);
    bus(1'b0, pga_pkg::REG_ACK_STAT_ADDR, 32'h0, q);
    chk(q, 32'h00000800);
    bus(1'b0, 8'h40, 32'h0, q);
    chk(q, pga_pkg::UNMAPPED_DATA);
    // second reset mid-run: outputs and config go back to reset values
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({12'h000, ack_busy, tx_sop_type, tx_header}, 32'h0);
    resetn <= 1'b1;
    bus(1'b0, pga_pkg::REG_ACK_HDR_ADDR, 32'h0, q);
    chk(q, {24'h0, pga_pkg::ACK_HDR_RESET});
    msg(3'h0, 3'h2, 1'b1, q);
    chk({30'h0, q[20:19]}, 32'h0);
    bus(1'b0, pga_pkg::REG_ACK_STAT_ADDR, 32'h0, q);
    chk(q, 32'h00000000);
    finish_test;
  end
  // watchdog well past the expected few hundred cycles
  initial
  begin
    #200000;
    bad_count++;
    finish_test;
  end
endmodule
`default_nettype wire
